// ==== core/mlb_core.sv ====
// Transmit fetch, serializer and loopback capture for the network controller
//
// Contract
// - Word mode, order clear: even byte low lane
// - Word mode, order set: even byte high lane
// - Byte mode: consecutive bytes on low lane
// - Send bytes in buffer order, LSB first
// - Mode low-only: serializer feeds deserializer internally
// - Mode high-only: force codec loopback control
// - Both bits: loop through external cable
// - Loopback splits FIFO into two halves
// - Loopback fetches only single bytes
// - Keep last eight received bytes, read sequentially
// - CRC appended only when inhibit clear
// - Normal transmit command starts loopback; address checked
// - Twisted pair link fail disables transmitter
// - Read pointer advances within four clocks, waits
// - Capture starts at zero, wraps, overwrites
// - Then low count, high count, high again
// - 64-byte frame: counts, last byte, CRC
// - 8N plus 5: bytes, then counts
// - Loopback sets only packet sent flag
// - 56 preamble bits, then 8-bit synch
`timescale 1ns/1ps
module mlb_core
    import mlb_pkg::*;
#(
    parameter int FIFO_DEPTH = TX_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // Configuration
    input wire logic WORD_TRANSFER_SELECT,
    input wire logic BYTE_ORDER_SELECT,
    input wire logic LOOP_SELECT_HIGH,
    input wire logic LOOP_SELECT_LOW,
    input wire logic CRC_INHIBIT,
    input wire logic TWISTED_PAIR_MODE,
    input wire logic LINK_FAIL,
    input wire logic [7:0] TX_PAGE_START,
    input wire logic [7:0] TX_COUNT_LOW,
    input wire logic [7:0] TX_COUNT_HIGH,
    input wire logic [47:0] STATION_ADDRESS,
    // Command
    input wire logic TX_START,
    // Buffer memory
    output logic MEM_REQ,
    output logic [15:0] MEM_ADDR,
    input wire logic MEM_GNT,
    input wire logic [15:0] MEM_DATA,
    // Line side
    output logic TX_DATA,
    output logic TX_ENABLE,
    output logic CODEC_LOOP_FORCE,
    input wire logic RX_DATA,
    input wire logic RX_BIT_VALID,
    input wire logic RX_CARRIER,
    // FIFO read port
    input wire logic FIFO_RD_N,
    output logic [7:0] FIFO_RDATA,
    output logic FIFO_WAIT,
    // Status
    output logic TX_BUSY,
    output logic PACKET_SENT_FLAG,
    output logic PACKET_RECEIVED_FLAG,
    output logic ADDRESS_MATCH
);
    localparam int LW = $clog2(FIFO_DEPTH + 1);

    generate
        if (FIFO_DEPTH < 16) begin : g_bad_depth
            $error("mlb_core: FIFO_DEPTH must hold at least two capture halves");
        end
    endgenerate

    typedef enum logic [1:0] {F_IDLE, F_REQ, F_SECOND} mlb_fetch_t;
    typedef enum logic [2:0] {T_IDLE, T_WAIT, T_PRE, T_DATA, T_CRC} mlb_tx_t;
    typedef enum logic [1:0] {R_IDLE, R_HUNT, R_DATA, R_TAIL} mlb_rx_t;

    mlb_stream_if #(.W(8)) tx_in ();
    mlb_stream_if #(.W(8)) tx_out ();
    logic [LW-1:0] level;

    // Even-numbered byte lane of a buffer word
    function automatic logic [7:0] even_lane(input logic [15:0] w, input logic byte_order_select);
        return byte_order_select ? w[15:8] : w[7:0];
    endfunction

    // Loop mode register
    mlb_loop_t lb, next_lb;
    logic in_loop;
    logic next_codec;
    assign in_loop = (lb != MLB_LB_OFF);

    always_comb begin
        next_lb = mlb_loop_decode(LOOP_SELECT_HIGH, LOOP_SELECT_LOW);
        next_codec = (mlb_loop_decode(LOOP_SELECT_HIGH, LOOP_SELECT_LOW) == MLB_LB_CODEC);
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            lb <= MLB_LB_OFF;
            CODEC_LOOP_FORCE <= 1'b0;
        end else begin
            lb <= next_lb;
            CODEC_LOOP_FORCE <= next_codec;
        end
    end

    // Buffer fetch into the transmit FIFO
    mlb_fetch_t fst, next_fst;
    logic [15:0] left, next_left, next_addr;
    logic [7:0] hold, next_hold;
    logic next_req, room;
    int limit;

    always_comb begin
        // Loopback keeps the upper half free for the receive side
        limit = in_loop ? FIFO_DEPTH / 2 : FIFO_DEPTH;
        room = (int'(level) + 2 <= limit);
        next_fst = fst;
        next_left = left;
        next_addr = MEM_ADDR;
        next_hold = hold;
        next_req = 1'b0;
        tx_in.valid = 1'b0;
        tx_in.data = hold;
        unique case (fst)
            F_IDLE: begin
            end
            F_REQ: begin
                if (MEM_REQ && MEM_GNT) begin
                    tx_in.valid = 1'b1;
                    if (!WORD_TRANSFER_SELECT) begin
                        tx_in.data = MEM_DATA[7:0];
                        next_left = left - 16'h0001;
                        next_addr = MEM_ADDR + 16'h0001;
                    end else begin
                        tx_in.data = even_lane(MEM_DATA, BYTE_ORDER_SELECT);
                        next_addr = MEM_ADDR + 16'h0002;
                        next_left = (left > 16'h0002) ? left - 16'h0002 : 16'h0000;
                        if (!in_loop && left >= 16'h0002) begin
                            next_hold = BYTE_ORDER_SELECT ? MEM_DATA[7:0] : MEM_DATA[15:8];
                            next_fst = F_SECOND;
                        end
                        // Loopback drops the odd lane: one byte per word, count is doubled
                    end
                    if (next_fst == F_REQ && next_left == 16'h0000) begin
                        next_fst = F_IDLE;
                    end
                end else begin
                    next_req = room;
                end
            end
            F_SECOND: begin
                tx_in.valid = 1'b1;
                if (tx_in.ready) begin
                    next_fst = (left == 16'h0000) ? F_IDLE : F_REQ;
                end
            end
        endcase
        if (TX_START && fst == F_IDLE) begin
            next_left = {TX_COUNT_HIGH, TX_COUNT_LOW};
            next_addr = 16'(TX_PAGE_START) << PAGE_SHIFT;
            next_fst = ({TX_COUNT_HIGH, TX_COUNT_LOW} != 16'h0000) ? F_REQ : F_IDLE;
            next_req = 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            fst <= F_IDLE;
            left <= 16'h0000;
            MEM_ADDR <= 16'h0000;
            hold <= 8'h00;
            MEM_REQ <= 1'b0;
        end else begin
            fst <= next_fst;
            left <= next_left;
            MEM_ADDR <= next_addr;
            hold <= next_hold;
            MEM_REQ <= next_req;
        end
    end

    mlb_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .clk(CLK),
        .rst_n(RSTN),
        .flush(TX_START && !TX_BUSY),
        .wr(tx_in),
        .rd(tx_out),
        .level(level)
    );

    // Serializer
    mlb_tx_t tst, next_tst;
    logic [DIV_W-1:0] div, next_div;
    logic [7:0] sh, next_sh;
    logic [2:0] bcnt, next_bcnt;
    logic [3:0] pre, next_pre;
    logic [31:0] crc, next_crc;
    logic [4:0] ccnt, next_ccnt;
    logic line_on, next_line_on, bit_stb, next_bit_stb, next_line_bit;
    logic next_sent, next_txen, next_busy, bit_en, emit;

    always_comb begin
        bit_en = (div == DIV_W'(BIT_DIV - 1));
        emit = (tst == T_PRE) || (tst == T_DATA) || (tst == T_CRC);
        next_div = bit_en ? '0 : div + 1'b1;
        next_tst = tst;
        next_sh = sh;
        next_bcnt = bcnt;
        next_pre = pre;
        next_crc = crc;
        next_ccnt = ccnt;
        next_line_on = line_on;
        next_line_bit = TX_DATA;
        next_bit_stb = 1'b0;
        next_sent = 1'b0;
        tx_out.ready = 1'b0;
        if (bit_en) begin
            next_line_on = emit;
            if (emit) begin
                next_bit_stb = 1'b1;
                next_line_bit = (tst == T_CRC) ? ~crc[31] : sh[0];
                next_bcnt = bcnt + 3'd1;
                next_sh = {1'b0, sh[7:1]};
            end
            if (tst == T_DATA) begin
                next_crc = mlb_crc_step(crc, sh[0]);
            end
            if (tst == T_WAIT && tx_out.valid) begin
                next_tst = T_PRE;
                next_sh = PREAMBLE_BYTE;
                next_pre = 4'd1;
                next_bcnt = 3'd0;
            end
            if (tst == T_CRC) begin
                next_crc = {crc[30:0], 1'b0};
                next_ccnt = ccnt + 5'd1;
                if (ccnt == 5'(CRC_BITS - 1)) begin
                    next_tst = T_IDLE;
                    next_sent = 1'b1;
                end
            end else if (emit && bcnt == 3'(BYTE_BITS - 1)) begin
                if (tst == T_PRE && pre < 4'(PRE_BYTES)) begin
                    next_sh = PREAMBLE_BYTE;
                    next_pre = pre + 4'd1;
                end else if (tst == T_PRE && pre == 4'(PRE_BYTES)) begin
                    next_sh = SYNCH_BYTE;
                    next_pre = pre + 4'd1;
                end else if (tx_out.valid) begin
                    tx_out.ready = 1'b1;
                    next_sh = tx_out.data;
                    next_tst = T_DATA;
                end else if (!CRC_INHIBIT) begin
                    // An underrun also lands here and ends the frame early
                    next_tst = T_CRC;
                    next_ccnt = 5'd0;
                end else begin
                    next_tst = T_IDLE;
                    next_sent = 1'b1;
                end
            end
        end
        if (TX_START && tst == T_IDLE) begin
            next_tst = T_WAIT;
            next_crc = CRC_INIT;
        end
        next_busy = (next_tst != T_IDLE) || (next_fst != F_IDLE);
        // Not driven out during controller-internal loop; link fail gags the driver only in twisted-pair mode
        next_txen = next_line_on && (lb != MLB_LB_MAC)
            && !(TWISTED_PAIR_MODE && LINK_FAIL);
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            tst <= T_IDLE;
            div <= '0;
            sh <= 8'h00;
            bcnt <= 3'd0;
            pre <= 4'd0;
            crc <= CRC_INIT;
            ccnt <= 5'd0;
            line_on <= 1'b0;
            bit_stb <= 1'b0;
            TX_DATA <= 1'b0;
            TX_ENABLE <= 1'b0;
            PACKET_SENT_FLAG <= 1'b0;
            TX_BUSY <= 1'b0;
        end else begin
            tst <= next_tst;
            div <= next_div;
            sh <= next_sh;
            bcnt <= next_bcnt;
            pre <= next_pre;
            crc <= next_crc;
            ccnt <= next_ccnt;
            line_on <= next_line_on;
            bit_stb <= next_bit_stb;
            TX_DATA <= next_line_bit;
            TX_ENABLE <= next_txen;
            PACKET_SENT_FLAG <= next_sent;
            TX_BUSY <= next_busy;
        end
    end

    // Deserializer and capture ring
    mlb_rx_t rst, next_rst;
    logic [7:0] receive_status_register, next_rsr, asm_byte;
    logic [2:0] rbit, next_rbit;
    logic [CAP_AW-1:0] wptr, next_wptr;
    logic [15:0] rcount, next_rcount;
    logic [1:0] tail, next_tail;
    logic [7:0] cap [CAP_DEPTH];
    logic [7:0] next_cap [CAP_DEPTH];
    logic match, next_match, s_bit, s_stb, s_car;

    always_comb begin
        // Internal loop taps the serializer before the pins
        s_bit = (lb == MLB_LB_MAC) ? TX_DATA : RX_DATA;
        s_stb = (lb == MLB_LB_MAC) ? bit_stb : RX_BIT_VALID;
        s_car = (lb == MLB_LB_MAC) ? line_on : RX_CARRIER;
        asm_byte = {s_bit, receive_status_register[7:1]};
        next_rst = rst;
        next_rsr = receive_status_register;
        next_rbit = rbit;
        next_wptr = wptr;
        next_rcount = rcount;
        next_tail = tail;
        next_cap = cap;
        next_match = match;
        unique case (rst)
            R_IDLE: begin
            end
            R_HUNT: begin
                if (s_stb) begin
                    next_rsr = asm_byte;
                    if (asm_byte == SYNCH_BYTE) begin
                        next_rst = R_DATA;
                        next_rbit = 3'd0;
                        next_rcount = 16'h0000;
                        next_match = 1'b1;
                    end
                end
            end
            R_DATA: begin
                if (s_stb) begin
                    next_rsr = asm_byte;
                    next_rbit = rbit + 3'd1;
                    if (rbit == 3'(BYTE_BITS - 1)) begin
                        next_cap[wptr] = asm_byte;
                        next_wptr = wptr + 1'b1;
                        next_rcount = rcount + 16'h0001;
                        if (rcount < 16'(STATION_BYTES)
                            && asm_byte != STATION_ADDRESS[8*rcount[2:0] +: 8]) begin
                            next_match = 1'b0;
                        end
                    end
                end else if (!s_car) begin
                    next_rst = R_TAIL;
                    next_tail = 2'd0;
                end
            end
            R_TAIL: begin
                // Low count, high count, then the high count again
                next_cap[wptr] = (tail == 2'd0) ? rcount[7:0] : rcount[15:8];
                next_wptr = wptr + 1'b1;
                next_tail = tail + 2'd1;
                if (tail == 2'(TAIL_WRITES - 1)) begin
                    next_rst = R_IDLE;
                end
            end
        endcase
        if (TX_START && in_loop && tst == T_IDLE) begin
            next_rst = R_HUNT;
            next_wptr = '0;
            next_rsr = 8'h00;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst <= R_IDLE;
            receive_status_register <= 8'h00;
            rbit <= 3'd0;
            wptr <= '0;
            rcount <= 16'h0000;
            tail <= 2'd0;
            match <= 1'b0;
            ADDRESS_MATCH <= 1'b0;
            PACKET_RECEIVED_FLAG <= 1'b0;
            for (int i = 0; i < CAP_DEPTH; i++) begin
                cap[i] <= 8'h00;
            end
        end else begin
            rst <= next_rst;
            receive_status_register <= next_rsr;
            rbit <= next_rbit;
            wptr <= next_wptr;
            rcount <= next_rcount;
            tail <= next_tail;
            match <= next_match;
            ADDRESS_MATCH <= next_match;
            // No status goes to memory in loopback, so never raised here
            PACKET_RECEIVED_FLAG <= 1'b0;
            cap <= next_cap;
        end
    end

    // Host read port on the capture ring
    logic rd_q, rd_s1, rd_s2, rd_s3, pend, next_pend, advance, next_wait;
    logic [CAP_AW-1:0] rptr, next_rptr;
    logic [7:0] next_rdata;

    always_comb begin
        // Strobe end is resynchronised before the pointer moves
        advance = rd_s2 && !rd_s3;
        next_rptr = advance ? rptr + 1'b1 : rptr;
        if (TX_START && in_loop && tst == T_IDLE) begin
            next_rptr = '0;
        end
        next_pend = pend;
        if (advance) begin
            next_pend = 1'b0;
        end
        if (FIFO_RD_N && !rd_q) begin
            next_pend = 1'b1;
        end
        next_wait = next_pend && !FIFO_RD_N;
        next_rdata = next_cap[next_rptr];
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rd_q <= 1'b1;
            rd_s1 <= 1'b1;
            rd_s2 <= 1'b1;
            rd_s3 <= 1'b1;
            pend <= 1'b0;
            rptr <= '0;
            FIFO_WAIT <= 1'b0;
            FIFO_RDATA <= 8'h00;
        end else begin
            rd_q <= FIFO_RD_N;
            rd_s1 <= FIFO_RD_N;
            rd_s2 <= rd_s1;
            rd_s3 <= rd_s2;
            pend <= next_pend;
            rptr <= next_rptr;
            FIFO_WAIT <= next_wait;
            FIFO_RDATA <= next_rdata;
        end
    end
endmodule // mlb_core

// ==== inc/mlb_pkg.sv ====
// Constants, types and decoders shared by the loopback diagnostics core
package mlb_pkg;
    // Line timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int BIT_PERIOD_NS = 100;
    localparam int BIT_DIV = BIT_PERIOD_NS / CLK_PERIOD_NS;
    localparam int DIV_W = $clog2(BIT_DIV);

    // Frame framing
    localparam int BYTE_BITS = 8;
    localparam int PRE_BITS = 56;
    localparam int PRE_BYTES = PRE_BITS / BYTE_BITS;
    localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
    localparam logic [7:0] SYNCH_BYTE = 8'hD5;
    localparam int CRC_BITS = 32;
    localparam logic [31:0] CRC_POLY = 32'h04C1_1DB7;
    localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;

    // Buffering and capture
    localparam int TX_FIFO_DEPTH = 32;
    localparam int CAP_DEPTH = 8;
    localparam int CAP_AW = $clog2(CAP_DEPTH);
    localparam int TAIL_WRITES = 3;
    localparam int STATION_BYTES = 6;
    localparam int PAGE_SHIFT = 8;
    localparam int RD_ADVANCE_MAX = 4;

    typedef enum logic [1:0] {MLB_LB_OFF, MLB_LB_MAC, MLB_LB_CODEC, MLB_LB_CABLE} mlb_loop_t;

    function automatic mlb_loop_t mlb_loop_decode(input logic high, input logic low);
        unique case ({high, low})
            2'b00: return MLB_LB_OFF;
            2'b01: return MLB_LB_MAC;
            2'b10: return MLB_LB_CODEC;
            2'b11: return MLB_LB_CABLE;
        endcase
    endfunction

    function automatic logic [31:0] mlb_crc_step(input logic [31:0] crc, input logic bit_in);
        return {crc[30:0], 1'b0} ^ ((crc[31] ^ bit_in) ? CRC_POLY : 32'h0000_0000);
    endfunction
endpackage

// ==== inc/mlb_stream_if.sv ====
// Byte stream carrier with valid and ready between core modules
`timescale 1ns/1ps
interface mlb_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface

// ==== core/mlb_fifo.sv ====
// Synchronous FIFO with parameterised width and depth
`timescale 1ns/1ps
module mlb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    // Streams
    mlb_stream_if.snk wr,
    mlb_stream_if.src rd,
    // Fill level
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    generate
        if (DEPTH < 4 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
            $error("mlb_fifo: DEPTH must be a power of two of at least 4");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr, next_wptr, rptr, next_rptr;
    logic [CW-1:0] cnt, next_cnt;
    logic push, pop;

    assign wr.ready = (cnt != CW'(DEPTH));
    assign rd.valid = (cnt != '0);
    assign rd.data = mem[rptr];
    assign level = cnt;

    always_comb begin
        push = wr.valid && wr.ready;
        pop = rd.valid && rd.ready;
        next_wptr = push ? wptr + 1'b1 : wptr;
        next_rptr = pop ? rptr + 1'b1 : rptr;
        next_cnt = cnt + CW'(push) - CW'(pop);
        if (flush) begin
            next_wptr = '0;
            next_rptr = '0;
            next_cnt = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr <= '0;
            rptr <= '0;
            cnt <= '0;
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            cnt <= next_cnt;
        end
    end

    // Storage needs no reset; empty flag guards stale words
    always_ff @(posedge clk) begin
        if (push && !flush) begin
            mem[wptr] <= wr.data;
        end
    end
endmodule // mlb_fifo

// ==== bench/mlb_core_sva.sv ====
// Port-level assertions for the loopback diagnostics core
`timescale 1ns/1ps
module mlb_core_sva (
    // Clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // Controls
    input wire logic LOOP_SELECT_HIGH,
    input wire logic LOOP_SELECT_LOW,
    input wire logic TWISTED_PAIR_MODE,
    input wire logic LINK_FAIL,
    input wire logic TX_START,
    input wire logic [7:0] TX_PAGE_START,
    input wire logic [7:0] TX_COUNT_LOW,
    input wire logic [7:0] TX_COUNT_HIGH,
    input wire logic FIFO_RD_N,
    // Responses
    input wire logic TX_BUSY,
    input wire logic MEM_REQ,
    input wire logic [15:0] MEM_ADDR,
    input wire logic TX_ENABLE,
    input wire logic CODEC_LOOP_FORCE,
    input wire logic FIFO_WAIT,
    input wire logic PACKET_SENT_FLAG,
    input wire logic PACKET_RECEIVED_FLAG
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    codec_on_a: assert property ((LOOP_SELECT_HIGH && !LOOP_SELECT_LOW) [*3] |-> CODEC_LOOP_FORCE)
        else $error("codec loop control not raised");
    internal_quiet_a: assert property ((!LOOP_SELECT_HIGH && LOOP_SELECT_LOW) [*3] |-> !TX_ENABLE)
        else $error("line driven in internal loop");
    link_fail_a: assert property ((TWISTED_PAIR_MODE && LINK_FAIL) [*2] |-> !TX_ENABLE)
        else $error("transmitter on with link failed");
    no_received_a: assert property (!PACKET_RECEIVED_FLAG)
        else $error("received flag set");
    sent_pulse_a: assert property (PACKET_SENT_FLAG |=> !PACKET_SENT_FLAG)
        else $error("sent flag longer than one cycle");
    tx_launch_a: assert property (TX_START && !TX_BUSY && (TX_COUNT_LOW | TX_COUNT_HIGH) != 8'h00
        |=> TX_BUSY ##1 MEM_REQ && MEM_ADDR == {TX_PAGE_START, 8'h00})
        else $error("transmit command not followed by fetch");
    read_wait_a: assert property ($rose(FIFO_RD_N) ##1 !FIFO_RD_N |-> ##[0:1] FIFO_WAIT)
        else $error("early reread without wait");
    read_advance_a: assert property ($rose(FIFO_RD_N) |-> ##5 !FIFO_WAIT)
        else $error("read pointer slow to advance");
endmodule // mlb_core_sva

bind mlb_core mlb_core_sva sva_i (.*);

// ==== bench/mlb_far_model.sv ====
// Buffer memory and line loop model facing the core
`timescale 1ns/1ps
module mlb_far_model (
    // Clock
    input wire logic clk,
    // Memory side
    input wire logic word_transfer_select,
    input wire logic byte_order_select,
    input wire logic req,
    input wire logic [15:0] addr,
    output logic gnt,
    output logic [15:0] data,
    // Line side
    input wire logic tx,
    input wire logic txen,
    output logic rx,
    output logic stb,
    output logic crs
);
    logic [7:0] mem [0:255];
    logic [7:0] a;
    int n = 0;
    int ph = 0;
    initial {gnt, data, rx, stb, crs} = '0;
    assign a = addr[7:0];
    always @(posedge clk) begin
        // Several cycles of latency, far below the allowed bound
        n <= (req && !gnt) ? n + 1 : 0;
        gnt <= req && !gnt && n == 3;
        // Unused lanes and idle bus never repeat the last value
        if (req && !gnt && n == 3) begin
            data <= !word_transfer_select ? {~data[15:8], mem[a]} :
                byte_order_select ? {mem[a], mem[a + 8'h01]} : {mem[a + 8'h01], mem[a]};
        end else begin
            data <= ~data;
        end
        crs <= txen;
        ph <= (txen && ph < 9) ? ph + 1 : 0;
        stb <= txen && ph == 4;
        rx <= txen ? tx : !rx;
    end
endmodule // mlb_far_model

// ==== bench/mlb_core_test.sv ====
// Self-checking bench for the loopback diagnostics core
`timescale 1ns/1ps
module mlb_core_test;
    logic clk = 0, rstn = 0, word_transfer_select = 0, byte_order_select = 0, lbh = 0, lbl = 0, tp = 0, lf = 0, crc_inh = 1;
    logic amatch;
    logic start = 0, rd_n = 1, gnt, req, txd, txen, force_lb, rxd, stb, crs, waitf, busy, sent;
    logic [7:0] cnt_l = 0, cnt_h = 0, rdata;
    logic [15:0] addr, mdata;
    int mismatches = 0, checked = 0;
    mlb_core uut (.CLK(clk), .RSTN(rstn), .WORD_TRANSFER_SELECT(word_transfer_select), .BYTE_ORDER_SELECT(byte_order_select),
        .LOOP_SELECT_HIGH(lbh), .LOOP_SELECT_LOW(lbl), .CRC_INHIBIT(crc_inh),
        .TWISTED_PAIR_MODE(tp), .LINK_FAIL(lf), .TX_PAGE_START(8'h00), .TX_COUNT_LOW(cnt_l),
        .TX_COUNT_HIGH(cnt_h), .STATION_ADDRESS(48'h353433323130), .TX_START(start),
        .MEM_REQ(req), .MEM_ADDR(addr), .MEM_GNT(gnt), .MEM_DATA(mdata), .TX_DATA(txd),
        .TX_ENABLE(txen), .CODEC_LOOP_FORCE(force_lb), .RX_DATA(rxd), .RX_BIT_VALID(stb),
        .RX_CARRIER(crs), .FIFO_RD_N(rd_n), .FIFO_RDATA(rdata), .FIFO_WAIT(waitf),
        .TX_BUSY(busy), .PACKET_SENT_FLAG(sent), .PACKET_RECEIVED_FLAG(), .ADDRESS_MATCH(amatch));
    mlb_far_model far (.clk(clk), .word_transfer_select(word_transfer_select), .byte_order_select(byte_order_select), .req(req), .addr(addr), .gnt(gnt),
        .data(mdata), .tx(txd), .txen(txen), .rx(rxd), .stb(stb), .crs(crs));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Thirteen bytes: 8 + 5 puts the count bytes at the ring tail
    task automatic launch(input logic h, input logic l, input logic w, input logic b);
        logic [7:0] i;
        {lbh, lbl, word_transfer_select, byte_order_select} = {h, l, w, b};
        for (i = 0; i < 8'h0D; i++) begin
            far.mem[w ? 2 * i : i] = 8'h30 + i;
            if (w) far.mem[2 * i + 1] = 8'hC0 + i;
        end
        cnt_l = (crc_inh ? 8'h0D : 8'h09) << w;
        repeat (3) @(negedge clk);
        chk(8'(force_lb), 8'(h & !l));
        start = 1;
        @(negedge clk) start = 0;
    endtask
    // Check bytes of the first len pattern bytes, in arrival order, low byte first
    function automatic logic [31:0] fcs(input int len);
        logic [31:0] c;
        logic [31:0] r;
        logic [7:0] b;
        c = mlb_pkg::CRC_INIT;
        for (int k = 0; k < len; k++) begin
            b = 8'h30 + 8'(k);
            for (int j = 0; j < 8; j++) begin
                c = {c[30:0], 1'b0} ^ ((c[31] ^ b[j]) ? mlb_pkg::CRC_POLY : 32'h0000_0000);
            end
        end
        r = {<<{c}};
        return ~r;
    endfunction
    task automatic drain(input string name);
        int n;
        logic [63:0] ring;
        ring = crc_inh ? 64'h0000_0D3C_3B3A_3938 : {24'h00_000D, fcs(9), 8'h38};
        for (n = 0; n < 6000 && sent !== 1'b1; n++) @(negedge clk);
        if (n == 6000) begin
            mismatches++;
            complete_run;
        end
        repeat (200) @(negedge clk);
        chk(8'(amatch), 8'h01);
        rd_n = 0;
        for (n = 0; n < 8; n++) begin
            chk(rdata, ring[8*n +: 8]);
            @(negedge clk) rd_n = 1;
            @(negedge clk) rd_n = 0;
            @(negedge clk);
            chk(8'(waitf), 8'h01);
            repeat (3) @(negedge clk);
            chk(8'(waitf), 8'h00);
        end
        rd_n = 1;
        $display("%s done", name);
    endtask
    task automatic test_cable;
        int n;
        logic [71:0] w;
        launch(1, 1, 0, 0);
        for (n = 0; n < 3000 && txen !== 1'b1; n++) @(negedge clk);
        if (n == 3000) begin
            mismatches++;
            complete_run;
        end
        repeat (5) @(negedge clk);
        for (n = 0; n < 72; n++) begin
            w = {txd, w[71:1]};
            repeat (10) @(negedge clk);
        end
        chk(8'(w[63:0] === 64'hD555_5555_5555_5555), 8'h01);
        chk(w[71:64], 8'h30);
        drain("cable");
    endtask
    task automatic test_link_fail;
        int n, hi;
        {tp, lf} = 2'b11;
        launch(1, 1, 0, 0);
        hi = 0;
        for (n = 0; n < 3000; n++) begin
            @(negedge clk);
            if (txen !== 1'b0) hi++;
        end
        chk(8'(hi), 8'h00);
        $display("link fail done");
    endtask
    // Nine bytes plus four check bytes also land as thirteen
    task automatic test_crc;
        crc_inh = 0;
        launch(0, 1, 0, 0);
        drain("internal crc");
        crc_inh = 1;
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rstn = 1;
        repeat (3) @(negedge clk);
        launch(0, 1, 0, 0);
        drain("internal byte");
        launch(1, 0, 1, 0);
        drain("codec word low");
        launch(0, 1, 1, 1);
        drain("internal word high");
        test_crc();
        test_cable();
        test_link_fail();
        complete_run;
    end
endmodule // mlb_core_test
